// File: common/tei_params.svh
`ifndef TEI_PARAMS_SVH
`define TEI_PARAMS_SVH

// Register byte offsets
`define TEI_CTRL_OFS 12'h000
`define TEI_TA_OFS 12'h004
`define TEI_TB_OFS 12'h008
`define TEI_IRQ_STAT_OFS 12'h00c
`define TEI_IRQ_MASK_OFS 12'h010

// Control register fields
`define TEI_CTRL_TA_RUN 0
`define TEI_CTRL_TB_RUN 1
`define TEI_CTRL_TA_GATE 2
`define TEI_CTRL_TB_GATE 3
`define TEI_CTRL_A_EDGE 4
`define TEI_CTRL_B_EDGE 5
`define TEI_CTRL_TA_CNT 6
`define TEI_CTRL_WIDTH 7
`define TEI_CTRL_RESET 7'h00

// Status fields: request flags and timer overflows
`define TEI_ST_A_REQ 0
`define TEI_ST_B_REQ 1
`define TEI_ST_TA_OVF 2
`define TEI_ST_TB_OVF 3
`define TEI_ST_WIDTH 4
`define TEI_ST_RESET 4'h0

`define TEI_TMR_WIDTH 16
`define TEI_TMR_RESET 16'h0000
`define TEI_TMR_STEP 16'h0001
`define TEI_RDATA_RESET 32'h0000_0000

`endif

// File: common/tei_pkg.sv
package tei_pkg;
   typedef logic [11:0] tei_addr_t;
   typedef logic [31:0] tei_data_t;
   typedef logic [15:0] tei_count_t;
endpackage

// File: design/tei_pin_sync.sv
`timescale 1ns/10ps
`include "tei_params.svh"

module tei_pin_sync (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic pinIn,
   output logic level,
   output logic fallPulse
);
   logic meta;
   logic sync;
   logic prev;
   logic next_meta;
   logic next_sync;
   logic next_prev;

   // Two stages, then one stage for the edge compare
   always_comb begin
      next_meta = pinIn;
      next_sync = meta;
      next_prev = sync;
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         meta <= 1'b1;
         sync <= 1'b1;
         prev <= 1'b1;
      end else begin
         meta <= next_meta;
         sync <= next_sync;
         prev <= next_prev;
      end
   end

   assign level = sync;
   assign fallPulse = prev & ~sync;
endmodule

// File: design/tei_timer_ext.sv
`timescale 1ns/10ps
`include "tei_params.svh"

// Overview of operation
// - With timer A gate select set, timer A counts only while ext_irq_pin_a is high.
// - With timer B gate select set, timer B counts only while ext_irq_pin_b is high.
// - With irq A edge select set, a falling edge on ext_irq_pin_a sets the A request flag.
// - With irq A edge select clear, a low level on ext_irq_pin_a sets the A request flag.
// - With irq B edge select set, a falling edge on ext_irq_pin_b sets the B request flag.
// - With irq B edge select clear, a low level on ext_irq_pin_b sets the B request flag.
// - In counter mode timer A steps by one per falling edge on the count pin.
module tei_timer_ext (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire tei_pkg::tei_addr_t paddr,
   input wire tei_pkg::tei_data_t pwdata,
   output tei_pkg::tei_data_t prdata,
   output logic pready,
   output logic pslverr,
   input wire logic extIrqPinA_n,
   input wire logic extIrqPinB_n,
   input wire logic timerACountPin,
   output logic irq
);
   import tei_pkg::*;

   logic pinALevel;
   logic pinAFall;
   logic pinBLevel;
   logic pinBFall;
   logic cntLevel;
   logic cntFall;

   // Gate and request pin A
   tei_pin_sync uSyncA (
      .mclk(mclk),
      .rst_n(rst_n),
      .pinIn(extIrqPinA_n),
      .level(pinALevel),
      .fallPulse(pinAFall)
   );

   // Gate and request pin B
   tei_pin_sync uSyncB (
      .mclk(mclk),
      .rst_n(rst_n),
      .pinIn(extIrqPinB_n),
      .level(pinBLevel),
      .fallPulse(pinBFall)
   );

   // Timer A count pin
   tei_pin_sync uSyncC (
      .mclk(mclk),
      .rst_n(rst_n),
      .pinIn(timerACountPin),
      .level(cntLevel),
      .fallPulse(cntFall)
   );

   logic [`TEI_CTRL_WIDTH-1:0] timerControlReg;
   logic [`TEI_CTRL_WIDTH-1:0] next_timerControlReg;
   tei_count_t timerA;
   tei_count_t timerB;
   tei_count_t next_timerA;
   tei_count_t next_timerB;
   logic [`TEI_ST_WIDTH-1:0] irqStat;
   logic [`TEI_ST_WIDTH-1:0] next_irqStat;
   logic [`TEI_ST_WIDTH-1:0] irqMask;
   logic [`TEI_ST_WIDTH-1:0] next_irqMask;
   tei_data_t next_prdata;

   // Bus decode and datapath controls
   logic wrEn;
   logic rdCapture;
   logic addrOk;
   logic selCtrl;
   logic selTa;
   logic selTb;
   logic selStat;
   logic selMask;
   logic timerAGateSelect;
   logic timerBGateSelect;
   logic irqAEdgeSelect;
   logic irqBEdgeSelect;
   logic timerACounter;
   logic runA;
   logic runB;
   logic stepA;
   logic stepB;
   logic ovfA;
   logic ovfB;
   logic setA;
   logic setB;
   logic [`TEI_ST_WIDTH-1:0] setBits;
   logic [`TEI_ST_WIDTH-1:0] clrBits;

   // One select per mapped register
   assign selCtrl = (paddr == `TEI_CTRL_OFS);
   assign selTa = (paddr == `TEI_TA_OFS);
   assign selTb = (paddr == `TEI_TB_OFS);
   assign selStat = (paddr == `TEI_IRQ_STAT_OFS);
   assign selMask = (paddr == `TEI_IRQ_MASK_OFS);
   assign addrOk = selCtrl | selTa | selTb | selStat | selMask;

   // Zero wait states: read data is loaded in the setup cycle
   assign wrEn = psel & penable & pwrite;
   assign rdCapture = psel & ~penable & ~pwrite;
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~addrOk;

   // Decoded control fields
   assign timerAGateSelect = timerControlReg[`TEI_CTRL_TA_GATE];
   assign timerBGateSelect = timerControlReg[`TEI_CTRL_TB_GATE];
   assign irqAEdgeSelect = timerControlReg[`TEI_CTRL_A_EDGE];
   assign irqBEdgeSelect = timerControlReg[`TEI_CTRL_B_EDGE];
   assign timerACounter = timerControlReg[`TEI_CTRL_TA_CNT];

   // Hardware run gates: a low pin holds the timer
   always_comb begin
      runA = timerControlReg[`TEI_CTRL_TA_RUN];
      if (timerAGateSelect && !pinALevel) begin
         runA = 1'b0;
      end
   end

   always_comb begin
      runB = timerControlReg[`TEI_CTRL_TB_RUN];
      if (timerBGateSelect && !pinBLevel) begin
         runB = 1'b0;
      end
   end

   // Timer A steps every clock, or once per count pin fall in counter mode
   always_comb begin
      stepA = 1'b0;
      if (runA) begin
         if (timerACounter) begin
            stepA = cntFall;
         end else begin
            stepA = 1'b1;
         end
      end
   end

   assign stepB = runB;
   assign ovfA = stepA & (&timerA);
   assign ovfB = stepB & (&timerB);

   // Request flag sources: edge or level trigger
   always_comb begin
      if (irqAEdgeSelect) begin
         setA = pinAFall;
      end else begin
         setA = ~pinALevel;
      end
   end

   always_comb begin
      if (irqBEdgeSelect) begin
         setB = pinBFall;
      end else begin
         setB = ~pinBLevel;
      end
   end

   // Status event sources
   always_comb begin
      setBits = '0;
      setBits[`TEI_ST_A_REQ] = setA;
      setBits[`TEI_ST_B_REQ] = setB;
      setBits[`TEI_ST_TA_OVF] = ovfA;
      setBits[`TEI_ST_TB_OVF] = ovfB;
   end

   // Write one to clear
   always_comb begin
      clrBits = '0;
      if (wrEn && selStat) begin
         clrBits = pwdata[`TEI_ST_WIDTH-1:0];
      end
   end

   // Control register
   always_comb begin
      next_timerControlReg = timerControlReg;
      if (wrEn && selCtrl) begin
         next_timerControlReg = pwdata[`TEI_CTRL_WIDTH-1:0];
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         timerControlReg <= `TEI_CTRL_RESET;
      end else begin
         timerControlReg <= next_timerControlReg;
      end
   end

   // Timer A: a bus write wins over a step in the same cycle
   always_comb begin
      next_timerA = timerA;
      if (stepA) begin
         next_timerA = timerA + `TEI_TMR_STEP;
      end
      if (wrEn && selTa) begin
         next_timerA = pwdata[`TEI_TMR_WIDTH-1:0];
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         timerA <= `TEI_TMR_RESET;
      end else begin
         timerA <= next_timerA;
      end
   end

   // Timer B: a bus write wins over a step in the same cycle
   always_comb begin
      next_timerB = timerB;
      if (stepB) begin
         next_timerB = timerB + `TEI_TMR_STEP;
      end
      if (wrEn && selTb) begin
         next_timerB = pwdata[`TEI_TMR_WIDTH-1:0];
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         timerB <= `TEI_TMR_RESET;
      end else begin
         timerB <= next_timerB;
      end
   end

   // Status flags: a set wins over a clear in the same cycle
   always_comb begin
      next_irqStat = (irqStat & ~clrBits) | setBits;
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         irqStat <= `TEI_ST_RESET;
      end else begin
         irqStat <= next_irqStat;
      end
   end

   // Interrupt mask
   always_comb begin
      next_irqMask = irqMask;
      if (wrEn && selMask) begin
         next_irqMask = pwdata[`TEI_ST_WIDTH-1:0];
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         irqMask <= `TEI_ST_RESET;
      end else begin
         irqMask <= next_irqMask;
      end
   end

   // Read data register; unmapped offsets read zero
   always_comb begin
      next_prdata = prdata;
      if (rdCapture) begin
         next_prdata = '0;
         if (selCtrl) begin
            next_prdata[`TEI_CTRL_WIDTH-1:0] = timerControlReg;
         end
         if (selTa) begin
            next_prdata[`TEI_TMR_WIDTH-1:0] = timerA;
         end
         if (selTb) begin
            next_prdata[`TEI_TMR_WIDTH-1:0] = timerB;
         end
         if (selStat) begin
            next_prdata[`TEI_ST_WIDTH-1:0] = irqStat;
         end
         if (selMask) begin
            next_prdata[`TEI_ST_WIDTH-1:0] = irqMask;
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         prdata <= `TEI_RDATA_RESET;
      end else begin
         prdata <= next_prdata;
      end
   end

   // Interrupt line, high while an unmasked flag is set
   assign irq = |(irqStat & irqMask);
endmodule

// File: tb/tb_tei_timer_ext.sv
`timescale 1ns/10ps
module tb_tei_timer_ext;
   import tei_pkg::*;
   logic mclk = 0;
   logic rst_n = 0;
   logic psel = 0;
   logic penable = 0;
   logic pwrite = 0;
   tei_addr_t paddr = 12'h00c;
   tei_data_t pwdata = 0;
   tei_data_t prdata;
   tei_data_t rd;
   logic pready, pslverr, irq, pinA_n, pinB_n, countPin;
   logic [2:0] want = 3'b111;
   int nErrors = 0;
   int numChecks = 0;
   tei_pin_source src (.mclk(mclk), .want(want), .pinA_n(pinA_n), .pinB_n(pinB_n),
      .countPin(countPin));
   tei_timer_ext dut (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .extIrqPinA_n(pinA_n), .extIrqPinB_n(pinB_n),
      .timerACountPin(countPin), .irq(irq));
   initial begin
      forever #50 mclk = ~mclk;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
   endtask
   task automatic apb(input logic w, input tei_addr_t a, input tei_data_t d);
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      pwrite <= 1'b0;
      paddr <= 12'h00c;
   endtask
   task automatic chk(input string nm, input tei_data_t s, input tei_data_t e);
      numChecks++;
      if (s !== e) begin
         nErrors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic completeRun();
      $display("Checks %0d mismatches %0d", numChecks, nErrors);
      if (nErrors == 0 && numChecks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   initial begin
      tick(20000);
      nErrors++;
      completeRun();
   end
   initial begin
      tick(16);
      rst_n <= 1'b1;
      apb(1'b0, 12'h000, 0);
      chk("ctrl reset", rd, 0);
      apb(1'b1, 12'h014, 32'hffffffff);
      apb(1'b0, 12'h014, 0);
      chk("unmapped", rd, 0);
      apb(1'b1, 12'h010, 32'hf);
      for (int m = 0; m < 2; m++) begin
         for (int i = 0; i < 2; i++) begin
            apb(1'b1, 12'h000, m ? 32'h30 : 32'h0);
            want[i] <= 1'b0;
            tick(12);
            apb(1'b0, 12'h00c, 0);
            chk("flag", rd[i], 1);
            chk("irq", irq, 1);
            apb(1'b1, 12'h010, 0);
            tick(1);
            chk("irq masked", irq, 0);
            apb(1'b0, 12'h010, 0);
            chk("mask cleared", rd, 0);
            apb(1'b1, 12'h00c, 32'hf);
            apb(1'b1, 12'h010, 32'hf);
            apb(1'b0, 12'h00c, 0);
            chk("flag held", rd[i], m == 0);
            want[i] <= 1'b1;
            tick(8);
            apb(1'b1, 12'h00c, 32'hf);
            apb(1'b0, 12'h00c, 0);
            chk("flag clear", rd[i], 0);
         end
      end
      apb(1'b1, 12'h000, 32'h0f);
      for (int i = 0; i < 2; i++) begin
         want[i] <= 1'b0;
         tick(4);
         apb(1'b1, tei_addr_t'(4 + 4 * i), 0);
         tick(10);
         apb(1'b0, tei_addr_t'(4 + 4 * i), 0);
         chk("gated", rd, 0);
         want[i] <= 1'b1;
         tick(10);
         apb(1'b0, tei_addr_t'(4 + 4 * i), 0);
         chk("running", rd != 0, 1);
      end
      apb(1'b1, 12'h000, 32'h41);
      apb(1'b1, 12'h004, 0);
      repeat (5) begin
         want[2] <= 1'b0;
         tick(3);
         want[2] <= 1'b1;
         tick(3);
      end
      tick(5);
      apb(1'b0, 12'h004, 0);
      chk("count", rd, 5);
      apb(1'b1, 12'h000, 32'h03);
      apb(1'b1, 12'h004, 32'hfff0);
      apb(1'b1, 12'h008, 32'hfff0);
      tick(20);
      apb(1'b0, 12'h00c, 0);
      chk("overflow", rd[3:2], 2'b11);
      completeRun();
   end
endmodule

// File: tb/tei_pin_source.sv
`timescale 1ns/10ps
// Drives the two request pins and the count pin from the levels the bench asks for
module tei_pin_source (
   input wire logic mclk,
   input wire logic [2:0] want,
   output logic pinA_n,
   output logic pinB_n,
   output logic countPin
);
   initial {countPin, pinB_n, pinA_n} = 3'b111;
   always @(posedge mclk) begin
      {countPin, pinB_n, pinA_n} <= want;
   end
endmodule

// File: tb/tei_timer_ext_assertions.sv
`timescale 1ns/10ps
module tei_timer_ext_assertions (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire tei_pkg::tei_addr_t paddr,
   input wire tei_pkg::tei_data_t prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic extIrqPinA_n,
   input wire logic extIrqPinB_n,
   input wire logic irq
);
   import tei_pkg::*;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   bus_ready_a: assert property (psel && penable |-> pready)
      else $error("pready low in access");
   unmapped_err_a: assert property (psel && penable && paddr > 12'h010 |-> pslverr)
      else $error("no error on unmapped access");
   mapped_ok_a: assert property (psel && penable && paddr == 12'h000 |-> !pslverr)
      else $error("error on mapped access");
   unmapped_zero_a: assert property (psel && penable && !pwrite && paddr > 12'h010
      |-> prdata == 32'h0)
      else $error("unmapped read not zero");
   status_upper_a: assert property (psel && penable && !pwrite && paddr == 12'h00c
      |-> prdata[31:4] == 28'h0)
      else $error("status upper bits set");
   irq_quiet_a: assert property (psel && penable && !pwrite && paddr == 12'h010 &&
      prdata[3:0] == 4'h0 |-> !irq)
      else $error("irq with zero mask");
   flag_a_set_a: assert property ($fell(extIrqPinA_n) ##0
      (!psel)[*8] ##1 (!psel)[*4] ##1 (psel && !penable && !pwrite && paddr == 12'h00c)
      ##1 (psel && penable) |-> prdata[0])
      else $error("request A not set");
   flag_b_set_a: assert property ($fell(extIrqPinB_n) ##0
      (!psel)[*8] ##1 (!psel)[*4] ##1 (psel && !penable && !pwrite && paddr == 12'h00c)
      ##1 (psel && penable) |-> prdata[1])
      else $error("request B not set");
endmodule
bind tei_timer_ext tei_timer_ext_assertions u_chk (.mclk(mclk), .rst_n(rst_n), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .extIrqPinA_n(extIrqPinA_n), .extIrqPinB_n(extIrqPinB_n), .irq(irq));
